// ---- logic/sar_adc_defs.vh ----
// Purpose: Constants for the converter start and serial readout logic
// Assumes: Included by the readout module, which passes the FIFO sizes to its sample FIFO as parameters
// Notes: Times are in ns; cycle counts derive from the clock period

`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

`define RESULT_BITS 16
`define RESULT_MSB 15
`define RESULT_RST 16'h0000
`define CLK_PERIOD_NS 100
`define CONV_TIME_NS 5000
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CONV_CNT_W 12
`define BIT_CNT_W 5
`define LAST_BIT_IDX 5'h0f
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define PIN_COUNT 3
`define PIN_CS 0
`define PIN_DIN 1
`define PIN_SCLK 2
`define PIN_RST 3'h2

`endif

// ---- logic/sample_fifo.v ----
// Purpose: Small synchronous FIFO carrying conversion results
// Assumes: Single clock, synchronous active-high reset
// Notes: Ready and valid on both sides; full and empty are exact
`timescale 1ns/1ps

module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  // ****************************************
  // Storage and pointers
  // ****************************************
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  wire [AW:0] depth_val;

  assign depth_val = DEPTH[AW:0];
  assign in_ready_o = (count_r != depth_val);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  // ****************************************
  // Write side
  // ****************************************
  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // ****************************************
  // Pointer and occupancy update
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ---- logic/sar_adc_serial_readout.v ----
// Purpose: Conversion start, interface mode choice and serial result readout
// Assumes: Pins arrive asynchronously; the analog core gives an offset-binary code
// Notes: The serial clock is sampled by clk_i and must be well below its rate
`timescale 1ns/1ps
`include "sar_adc_defs.vh"

module sar_adc_serial_readout #(
  parameter RES_W = `RESULT_BITS,
  parameter CONV_CYCLES = `CONV_CYCLES,
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW
) (
  input wire clk_i,
  input wire rst_i,
  input wire conversion_start_pin_i,
  input wire chain_in_i,
  input wire sclk_i,
  input wire [RES_W-1:0] core_code_i,
  output wire dout_o,
  output wire dout_oe_o,
  output wire power_down_o,
  output wire converting_o,
  output wire sample_o,
  output wire daisy_mode_o
);

  // ****************************************
  // State encoding
  // ****************************************
  localparam [2:0] ST_ACQ = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_PUSH = 3'b100;
  // Synchroniser reset levels match the idle pins, so no false edge follows reset
  localparam [`PIN_COUNT-1:0] PIN_RST_V = `PIN_RST;

  // ****************************************
  // Declarations
  // ****************************************
  reg [`PIN_COUNT-1:0] s1_r;
  reg [`PIN_COUNT-1:0] s2_r;
  reg [`PIN_COUNT-1:0] s3_r;
  reg [`PIN_COUNT-1:0] pin_r;
  reg [`PIN_COUNT-1:0] pin_prev_r;
  reg [2:0] state_r;
  reg [`CONV_CNT_W-1:0] conv_cnt_r;
  reg daisy_r;
  reg power_down_r;
  reg converting_r;
  reg sample_r;
  reg [RES_W-1:0] captured_r;
  reg [RES_W-1:0] result_r;
  reg [RES_W-1:0] shift_r;
  reg [`BIT_CNT_W-1:0] bit_cnt_r;
  reg frame_r;
  reg loaded_r;
  reg dout_r;
  reg dout_oe_r;
  wire cs_lvl;
  wire din_lvl;
  wire cs_rise;
  wire sel_now;
  wire sel_prev;
  wire sel_fall;
  wire sel_rise;
  wire sclk_fall;
  wire start_conv;
  wire conv_last;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [RES_W-1:0] fifo_out_data;
  wire pop;

  // ****************************************
  // Functions
  // ****************************************
  function rise_of;
    input [`PIN_COUNT-1:0] now;
    input [`PIN_COUNT-1:0] prev;
    input integer idx;
    begin
      rise_of = now[idx] & ~prev[idx];
    end
  endfunction

  function fall_of;
    input [`PIN_COUNT-1:0] now;
    input [`PIN_COUNT-1:0] prev;
    input integer idx;
    begin
      fall_of = ~now[idx] & prev[idx];
    end
  endfunction

  // Offset-binary core code to two's complement
  function [RES_W-1:0] to_twos;
    input [RES_W-1:0] code;
    begin
      to_twos = {~code[RES_W-1], code[RES_W-2:0]};
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_r[gi] <= PIN_RST_V[gi];
          s2_r[gi] <= PIN_RST_V[gi];
          s3_r[gi] <= PIN_RST_V[gi];
          pin_r[gi] <= PIN_RST_V[gi];
          pin_prev_r[gi] <= PIN_RST_V[gi];
        end else begin
          s1_r[gi] <= (gi == `PIN_CS) ? conversion_start_pin_i :
                      (gi == `PIN_DIN) ? chain_in_i : sclk_i;
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            pin_r[gi] <= s3_r[gi];
          end
          pin_prev_r[gi] <= pin_r[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Edge detection
  // ****************************************
  assign cs_lvl = pin_r[`PIN_CS];
  assign din_lvl = pin_r[`PIN_DIN];
  assign cs_rise = rise_of(pin_r, pin_prev_r, `PIN_CS);
  assign sclk_fall = fall_of(pin_r, pin_prev_r, `PIN_SCLK);
  // Deselected while both start pin and chain input are high
  assign sel_now = ~(pin_r[`PIN_CS] & pin_r[`PIN_DIN]);
  assign sel_prev = ~(pin_prev_r[`PIN_CS] & pin_prev_r[`PIN_DIN]);
  assign sel_fall = sel_now & ~sel_prev;
  assign sel_rise = ~sel_now & sel_prev;

  assign start_conv = (state_r == ST_ACQ) & cs_rise;
  assign conv_last = (conv_cnt_r == CONV_CYCLES[`CONV_CNT_W-1:0] - 1'b1);

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_ACQ;
      conv_cnt_r <= {`CONV_CNT_W{1'b0}};
      daisy_r <= 1'b0;
      power_down_r <= 1'b1;
      converting_r <= 1'b0;
      sample_r <= 1'b0;
      captured_r <= `RESULT_RST;
    end else begin
      sample_r <= 1'b0;
      case (state_r)
        ST_ACQ: begin
          if (start_conv) begin
            state_r <= ST_CONV;
            conv_cnt_r <= {`CONV_CNT_W{1'b0}};
            daisy_r <= ~din_lvl;
            power_down_r <= 1'b0;
            converting_r <= 1'b1;
            sample_r <= 1'b1;
          end
        end
        ST_CONV: begin
          // Pin levels are not looked at until the count ends
          if (conv_last) begin
            state_r <= ST_PUSH;
            captured_r <= to_twos(core_code_i);
          end else begin
            conv_cnt_r <= conv_cnt_r + 1'b1;
          end
        end
        ST_PUSH: begin
          // Stalls here while the result FIFO is full
          if (fifo_in_ready) begin
            state_r <= ST_ACQ;
            power_down_r <= 1'b1;
            converting_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_ACQ;
        end
      endcase
    end
  end

  // ****************************************
  // Result FIFO
  // ****************************************
  assign fifo_in_valid = (state_r == ST_PUSH);
  assign fifo_out_ready = (state_r == ST_ACQ) & ~frame_r;
  assign pop = fifo_out_valid & fifo_out_ready;

  sample_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(captured_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // ****************************************
  // Held result
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= `RESULT_RST;
      loaded_r <= 1'b0;
    end else if (start_conv) begin
      loaded_r <= 1'b0;
    end else if (pop) begin
      result_r <= fifo_out_data;
      loaded_r <= 1'b1;
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= `RESULT_RST;
      bit_cnt_r <= {`BIT_CNT_W{1'b0}};
      frame_r <= 1'b0;
      dout_r <= 1'b0;
      dout_oe_r <= 1'b0;
    end else if (start_conv) begin
      // Output floats for the conversion unless daisy chain mode sees start pin and chain input both low
      frame_r <= 1'b0;
      dout_oe_r <= 1'b0;
      bit_cnt_r <= {`BIT_CNT_W{1'b0}};
    end else if (pop & daisy_r) begin
      // Daisy chain: load and present MSB as soon as the result lands
      shift_r <= fifo_out_data;
      dout_r <= fifo_out_data[`RESULT_MSB];
      dout_oe_r <= 1'b1;
      frame_r <= 1'b1;
      bit_cnt_r <= {`BIT_CNT_W{1'b0}};
    end else if (daisy_r) begin
      if (frame_r & sclk_fall) begin
        shift_r <= {shift_r[RES_W-2:0], din_lvl};
        dout_r <= shift_r[RES_W-2];
      end else if (~frame_r & ~cs_lvl & ~din_lvl) begin
        dout_r <= 1'b0;
        dout_oe_r <= 1'b1;
      end
    end else if (~frame_r) begin
      // Readout only while acquiring a loaded result
      if (sel_fall & loaded_r & (state_r == ST_ACQ)) begin
        shift_r <= result_r;
        dout_r <= result_r[`RESULT_MSB];
        dout_oe_r <= 1'b1;
        frame_r <= 1'b1;
        bit_cnt_r <= {`BIT_CNT_W{1'b0}};
      end
    end else if (sel_rise) begin
      dout_oe_r <= 1'b0;
      frame_r <= 1'b0;
    end else if (sclk_fall) begin
      if (bit_cnt_r == `LAST_BIT_IDX) begin
        dout_oe_r <= 1'b0;
        frame_r <= 1'b0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
        shift_r <= {shift_r[RES_W-2:0], 1'b0};
        dout_r <= shift_r[RES_W-2];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dout_o = dout_r;
  assign dout_oe_o = dout_oe_r;
  assign power_down_o = power_down_r;
  assign converting_o = converting_r;
  assign sample_o = sample_r;
  assign daisy_mode_o = daisy_r;

endmodule

// ---- tb/adc_readout_chk.sv ----
// Purpose: Assertions on the start, conversion and serial output ports
// Assumes: Synchronous active-high reset, one clock domain
// Notes: Pin changes take about five clocks to reach the outputs
`timescale 1ns/1ps
module adc_readout_chk #(
  parameter CONV_CYCLES = 50
) (
  input wire clk_i,
  input wire rst_i,
  input wire conversion_start_pin_i,
  input wire chain_in_i,
  input wire dout_o,
  input wire dout_oe_o,
  input wire power_down_o,
  input wire converting_o,
  input wire sample_o,
  input wire daisy_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [15:0] conv_cnt_r;
  always @(posedge clk_i) begin
    if (rst_i || !converting_o) conv_cnt_r <= 16'h0000;
    else conv_cnt_r <= conv_cnt_r + 16'h0001;
  end
  sample_pd_a: assert property (sample_o |-> $past(power_down_o))
    else $error("conversion started outside acquisition");
  sample_conv_a: assert property (sample_o |-> converting_o ##1 !sample_o)
    else $error("sample pulse without conversion");
  pd_excl_a: assert property (power_down_o |-> !converting_o)
    else $error("powered down while converting");
  pd_after_a: assert property ($fell(converting_o) |-> power_down_o)
    else $error("no power down after conversion");
  conv_len_a: assert property ($fell(converting_o) |-> conv_cnt_r >= CONV_CYCLES)
    else $error("conversion cut short");
  mode_hold_a: assert property (converting_o && $past(converting_o) |-> $stable(daisy_mode_o))
    else $error("mode changed during conversion");
  oe_conv_a: assert property (converting_o && !daisy_mode_o |-> !dout_oe_o)
    else $error("output driven during conversion");
  cs_float_a: assert property ((!daisy_mode_o && conversion_start_pin_i && chain_in_i) [*8]
    |-> !dout_oe_o)
    else $error("output not floated when deselected");
  daisy_low_a: assert property ((daisy_mode_o && !conversion_start_pin_i && !chain_in_i) [*8]
    |-> dout_oe_o && !dout_o)
    else $error("chain output not low");
endmodule
bind sar_adc_serial_readout adc_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .conversion_start_pin_i(conversion_start_pin_i),
  .chain_in_i(chain_in_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .power_down_o(power_down_o), .converting_o(converting_o), .sample_o(sample_o),
  .daisy_mode_o(daisy_mode_o));

// ---- tb/adc_host_model.sv ----
// Purpose: Serial host driving start, chain or select, and serial clock
// Assumes: Pins change on the falling clk edge; serial clock idles low
// Notes: Each bit is captured just before its serial clock fall
`timescale 1ns/1ps
module adc_host_model (
  input wire clk_i,
  input wire line_i,
  output reg start_o,
  output reg din_o,
  output reg sclk_o,
  output reg [31:0] rx_o,
  output reg rx_tog_o
);
  initial begin
    start_o = 1'b0;
    din_o = 1'b1;
    sclk_o = 1'b0;
    rx_o = 32'h0000_0000;
    rx_tog_o = 1'b0;
  end
  task wait_clk(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  // Mode 0 three-wire, 1 four-wire, 2 daisy chain
  task frame(input integer mode, input integer nbits, input [15:0] chain);
    integer i;
    begin
      din_o = (mode != 2);
      wait_clk(4);
      start_o = 1'b0;
      wait_clk(4);
      start_o = 1'b1;
      wait_clk(6);
      start_o = (mode != 0);
      din_o = (mode == 0);
      wait_clk(4);
      start_o = 1'b1;
      din_o = (mode != 2);
      wait_clk(30);
      start_o = (mode != 0);
      din_o = (mode == 0);
      wait_clk(8);
      rx_o = 32'h0000_0000;
      for (i = 0; i < nbits; i = i + 1) begin
        sclk_o = 1'b1;
        if (mode == 2) din_o = (i < 16) ? chain[15 - (i % 16)] : 1'b0;
        wait_clk(4);
        rx_o = {rx_o[30:0], line_i};
        sclk_o = 1'b0;
        wait_clk(4);
      end
      start_o = (mode != 2);
      din_o = (mode != 2);
      wait_clk(32);
      rx_tog_o = ~rx_tog_o;
    end
  endtask
endmodule

// ---- tb/sar_adc_serial_readout_test.sv ----
// Purpose: Self-checking bench for conversion start and serial readout
// Assumes: Short conversion count of 8 clocks
// Notes: A floated output line toggles every clock
`timescale 1ns/1ps
module sar_adc_serial_readout_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] code = 16'h0000;
  reg line_q = 1'b0;
  reg [32:0] e;
  reg [32:0] exp_q[$];
  integer seed = 51789;
  integer bad_count = 0;
  integer comparisons = 0;
  integer k;
  wire start, din, sclk, dout, dout_oe, rx_tog, line;
  wire [31:0] rx;
  always #50 clk = ~clk;
  assign line = dout_oe ? dout : ~line_q;
  always @(posedge clk) line_q <= line;
  sar_adc_serial_readout #(.CONV_CYCLES(8)) DUT (
    .clk_i(clk), .rst_i(rst), .conversion_start_pin_i(start), .chain_in_i(din),
    .sclk_i(sclk), .core_code_i(code), .dout_o(dout), .dout_oe_o(dout_oe),
    .power_down_o(), .converting_o(), .sample_o(), .daisy_mode_o());
  adc_host_model host (
    .clk_i(clk), .line_i(line), .start_o(start), .din_o(din), .sclk_o(sclk),
    .rx_o(rx), .rx_tog_o(rx_tog));
  task check(input [32:0] seen, input [32:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("BAD at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  task test_done;
    begin
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task run(input integer mode, input integer n);
    reg [15:0] ch;
    begin
      code = $random(seed);
      ch = $random(seed);
      exp_q.push_back({mode == 2, {~code[15], code[14:0], ch} >> (32 - n)});
      host.frame(mode, n, ch);
    end
  endtask
  // ****************************************
  // Result monitor
  // ****************************************
  always @(rx_tog) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({1'b0, rx}, {1'b0, e[31:0]});
      check({32'h0, dout_oe}, {32'h0, e[32]});
      if (e[32]) check({32'h0, dout}, 33'h0);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
      run(0, 16);
      run(1, 16);
      run(2, 32);
    end
    run(0, 8);
    run(1, 8);
    repeat (4) @(negedge clk);
    test_done;
  end
endmodule
